// file: design/spp_consts.vh
// Constants for the serial port packetizer and modem control block
`ifndef SPP_CONSTS_VH
`define SPP_CONSTS_VH

// Register indices on the plain register port
`define SPP_REG_CFG       4'h0
`define SPP_REG_ICT       4'h1
`define SPP_REG_INACT     4'h2
`define SPP_REG_CTRL      4'h3
`define SPP_REG_STAT      4'h4
`define SPP_REG_TXDATA    4'h5
`define SPP_REG_RXDATA    4'h6
`define SPP_REG_RXCNT     4'h7

// Configuration field positions
`define SPP_CFG_BAUD_LSB  0
`define SPP_CFG_DBITS_LSB 4
`define SPP_CFG_PAR_LSB   6
`define SPP_CFG_STOP_LSB  8
`define SPP_CFG_FLOW_LSB  10
`define SPP_CFG_DTR_LSB   12
`define SPP_CFG_DSR_LSB   14
`define SPP_CFG_MODE_LSB  16

// Factory reset value: 9600, 8 data, no parity, 1 stop, no flow,
// DTR high, DSR ignored, TCP client
`define SPP_CFG_RESET     32'h00015564

// Mode codes
`define SPP_PAR_NONE      2'h1
`define SPP_PAR_ODD       2'h2
`define SPP_PAR_EVEN      2'h3
`define SPP_DB_SEVEN      2'h1
`define SPP_STOP_TWO      2'h2
`define SPP_FLOW_HW       2'h2
`define SPP_DTR_HIGH      2'h1
`define SPP_DTR_LOW       2'h2
`define SPP_DTR_CONN      2'h3
`define SPP_DSR_GATE      2'h2
`define SPP_DSR_OPEN      2'h3
`define SPP_HM_TCP_SRV    2'h0
`define SPP_HM_TCP_CLI    2'h1
`define SPP_HM_UDP_SRV    2'h2

// Timing
`define SPP_CLK_HZ        125000000
`define SPP_MS_CYC        (`SPP_CLK_HZ / 1000)
`define SPP_SEC_MS        1000
`define SPP_ICT_MAX       10000
`define SPP_INACT_MAX     3600
`define SPP_BUF_DEPTH     512

// Clocks per serial bit at 125 MHz for each baud code
`define SPP_BIT_1200      17'd104167
`define SPP_BIT_2400      17'd52083
`define SPP_BIT_4800      17'd26042
`define SPP_BIT_9600      17'd13021
`define SPP_BIT_19200     17'd6510
`define SPP_BIT_38400     17'd3255
`define SPP_BIT_57600     17'd2170
`define SPP_BIT_115200    17'd1085

`endif

// file: design/spp_top.v
// Serial port packetizer with modem control lines
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "spp_consts.vh"

// Overview of operation
// - Baud code 1..8 selects 1200 up to 115200 baud.
// - Reset framing is eight data bits, one stop, no parity.
// - Data bits code 1 means seven, code 2 means eight.
// - Stop code 1 means one stop bit, code 2 two.
// - Parity code 1 none, 2 odd, 3 even; checked on receive.
// - Flow control none (1, default) or RTS/CTS hardware (2).
// - DTR is output only, DSR is input only.
// - DTR constant high, constant low, or high while connected.
// - DSR open/close in client mode: high opens, low closes.
// - DSR gating in TCP server mode accepts only while DSR high.
// - Close connection after inactivity seconds; zero means unlimited.
// - Zero inactivity in TCP keeps link until close or probe fail.
// - Zero inactivity in UDP server keeps first peer until reset.
// - Received characters buffered; forwarded on full or gap timeout.
// - Buffer holds 512 bytes; sender keeps messages within it.
// - Gap timeout accepts 1 to 10000 ms; zero disables it.
module spp_top
(
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [3:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  input  wire        rxd_i,
  output reg         txd_o,
  output wire        rts_o,
  input  wire        cts_i,
  output reg         dtr_o,
  input  wire        dsr_i,
  input  wire        net_up_i,
  input  wire        net_req_i,
  input  wire        probe_fail_i,
  output reg         conn_open_o,
  output reg         conn_close_o,
  output wire        accept_ok_o,
  output reg         fwd_o
);

  // Configuration and control state
  reg [31:0] cfg;
  reg [13:0] ict_ms;
  reg [11:0] inact_s;
  reg        rx_perr;
  reg        rx_ovr;

  wire [3:0] baud_c = cfg[`SPP_CFG_BAUD_LSB +: 4];
  wire [1:0] dbits  = cfg[`SPP_CFG_DBITS_LSB +: 2];
  wire [1:0] par_c  = cfg[`SPP_CFG_PAR_LSB +: 2];
  wire [1:0] stop_c = cfg[`SPP_CFG_STOP_LSB +: 2];
  wire [1:0] flow_c = cfg[`SPP_CFG_FLOW_LSB +: 2];
  wire [1:0] dtr_c  = cfg[`SPP_CFG_DTR_LSB +: 2];
  wire [1:0] dsr_c  = cfg[`SPP_CFG_DSR_LSB +: 2];
  wire [1:0] mode_c = cfg[`SPP_CFG_MODE_LSB +: 2];
  wire       flow_on = (flow_c == `SPP_FLOW_HW);
  wire [3:0] nbits  = (dbits == `SPP_DB_SEVEN) ? 4'h7 : 4'h8;

  // Clocks per bit for a baud code
  function [16:0] spp_bit_cyc;
    input [3:0] code;
    begin
      case (code)
        4'h1:    spp_bit_cyc = `SPP_BIT_1200;
        4'h2:    spp_bit_cyc = `SPP_BIT_2400;
        4'h3:    spp_bit_cyc = `SPP_BIT_4800;
        4'h4:    spp_bit_cyc = `SPP_BIT_9600;
        4'h5:    spp_bit_cyc = `SPP_BIT_19200;
        4'h6:    spp_bit_cyc = `SPP_BIT_38400;
        4'h7:    spp_bit_cyc = `SPP_BIT_57600;
        4'h8:    spp_bit_cyc = `SPP_BIT_115200;
        default: spp_bit_cyc = `SPP_BIT_9600;
      endcase
    end
  endfunction

  wire [16:0] bit_cyc = spp_bit_cyc(baud_c);

  // Receive buffer
  reg [7:0]  buf_mem [0:`SPP_BUF_DEPTH-1];
  reg [8:0]  wr_ptr;
  reg [8:0]  rd_ptr;
  reg [9:0]  cnt;
  wire       buf_full = (cnt == 10'd`SPP_BUF_DEPTH);
  reg        fwd_act; // Forwarding in progress, drained by software
  assign rts_o = flow_on ? ~buf_full : 1'b1;

  // Transmitter
  localparam TX_IDLE = 2'h0;
  localparam TX_BITS = 2'h1;
  reg [1:0]  tx_st;
  reg [16:0] tx_div;
  reg [3:0]  tx_idx;
  reg [3:0]  tx_len;
  reg [11:0] tx_sh;
  reg [7:0]  tx_hold;
  reg        tx_pend;
  reg        tx_evt;
  wire       tx_go = tx_pend & (~flow_on | cts_i);

  // Frame word: start, data, optional parity, stop bits
  function [11:0] spp_frame;
    input [7:0] d;
    input [3:0] n;
    input [1:0] pc;
    reg         p;
    reg [11:0]  f;
    begin
      p = (n == 4'h7) ? ^d[6:0] : ^d;
      if (pc == `SPP_PAR_ODD)
        p = ~p;
      f = 12'hFFF;
      if (n == 4'h7)
        f[7:1] = d[6:0];
      else
        f[8:1] = d;
      f[0] = 1'b0;
      if (pc != `SPP_PAR_NONE)
        f[n + 4'h1] = p;
      spp_frame = f;
    end
  endfunction

  always @(posedge clk_i)
  begin
    tx_evt <= 1'b0;
    if (rst_i)
    begin
      tx_st   <= TX_IDLE;
      txd_o   <= 1'b1;
      tx_div  <= 17'h0;
      tx_idx  <= 4'h0;
      tx_len  <= 4'h0;
      tx_sh   <= 12'hFFF;
    end
    else
    begin
      case (tx_st)
        TX_IDLE:
        begin
          txd_o <= 1'b1;
          if (tx_go)
          begin
            tx_sh  <= spp_frame(tx_hold, nbits, par_c);
            tx_len <= nbits + ((par_c != `SPP_PAR_NONE) ? 4'h1 : 4'h0)
                      + ((stop_c == `SPP_STOP_TWO) ? 4'h3 : 4'h2);
            tx_idx <= 4'h0;
            tx_div <= 17'h0;
            tx_st  <= TX_BITS;
            tx_evt <= 1'b1;
          end
        end
        TX_BITS:
        begin
          txd_o <= tx_sh[tx_idx];
          if (tx_div == bit_cyc - 17'h1)
          begin
            tx_div <= 17'h0;
            if (tx_idx == tx_len - 4'h1)
              tx_st <= TX_IDLE;
            else
              tx_idx <= tx_idx + 4'h1;
          end
          else
            tx_div <= tx_div + 17'h1;
        end
        default: tx_st <= TX_IDLE;
      endcase
    end
  end

  // Receiver
  localparam RX_IDLE = 2'h0;
  localparam RX_BITS = 2'h1;
  reg [1:0]  rx_st;
  reg [16:0] rx_div;
  reg [3:0]  rx_idx;
  reg [9:0]  rx_sh;
  reg        rx_q;
  reg        rx_done;
  reg [7:0]  rx_byte;
  wire [3:0] rx_last = nbits + ((par_c != `SPP_PAR_NONE) ? 4'h1 : 4'h0);

  always @(posedge clk_i)
  begin
    rx_done <= 1'b0;
    rx_q    <= rxd_i;
    if (rst_i)
    begin
      rx_st   <= RX_IDLE;
      rx_div  <= 17'h0;
      rx_idx  <= 4'h0;
      rx_sh   <= 10'h0;
      rx_byte <= 8'h0;
    end
    else
    begin
      case (rx_st)
        RX_IDLE:
          if (!rx_q)
          begin
            rx_div <= {1'b0, bit_cyc[16:1]}; // Sample mid bit
            rx_idx <= 4'h0;
            rx_st  <= RX_BITS;
          end
        RX_BITS:
          if (rx_div == bit_cyc - 17'h1)
          begin
            rx_div <= 17'h0;
            rx_sh[rx_idx] <= rx_q;
            if (rx_idx == 4'h0 && rx_q)
              rx_st <= RX_IDLE; // False start
            else if (rx_idx == rx_last)
            begin
              rx_st   <= RX_IDLE;
              rx_done <= 1'b1;
              // Without parity the last data bit is still in rx_q
              if (par_c != `SPP_PAR_NONE)
                rx_byte <= (nbits == 4'h7) ? {1'b0, rx_sh[7:1]} : rx_sh[8:1];
              else
                rx_byte <= (nbits == 4'h7) ? {1'b0, rx_q, rx_sh[6:1]}
                                           : {rx_q, rx_sh[7:1]};
            end
            else
              rx_idx <= rx_idx + 4'h1;
          end
          else
            rx_div <= rx_div + 17'h1;
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  // Parity check of the captured word
  wire rx_pbit = rx_sh[rx_last];
  wire rx_pcalc = ((nbits == 4'h7) ? ^rx_sh[7:1] : ^rx_sh[8:1])
                  ^ (par_c == `SPP_PAR_ODD);
  wire rx_pbad = rx_done & (par_c != `SPP_PAR_NONE) & (rx_pbit != rx_pcalc);

  // Gap, inactivity and connection timers
  reg [16:0] ms_div;
  reg [13:0] gap_ms;
  reg [9:0]  sec_div;
  reg [11:0] idle_s;
  wire ms_tick = (ms_div == `SPP_MS_CYC - 1);
  wire rd_pop  = rd_i & (addr_i == `SPP_REG_RXDATA) & fwd_act;
  wire gap_hit = ms_tick & (ict_ms != 14'h0) & (cnt != 10'h0) & ~fwd_act
                 & (gap_ms == ict_ms - 14'h1);
  wire wr_tx   = wr_i & (addr_i == `SPP_REG_TXDATA);

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ms_div  <= 17'h0;
      gap_ms  <= 14'h0;
      sec_div <= 10'h0;
      idle_s  <= 12'h0;
    end
    else
    begin
      ms_div <= ms_tick ? 17'h0 : ms_div + 17'h1;
      if (rx_done)
        gap_ms <= 14'h0;
      else if (ms_tick && gap_ms != 14'h3FFF)
        gap_ms <= gap_ms + 14'h1;
      if (rx_done || tx_evt || !net_up_i)
      begin
        sec_div <= 10'h0;
        idle_s  <= 12'h0;
      end
      else if (ms_tick)
      begin
        if (sec_div == `SPP_SEC_MS - 1)
        begin
          sec_div <= 10'h0;
          if (idle_s != 12'hFFF)
            idle_s <= idle_s + 12'h1;
        end
        else
          sec_div <= sec_div + 10'h1;
      end
    end
  end

  wire inact_hit = (inact_s != 12'h0) && (idle_s >= inact_s);

  // Buffer fill, forward and drain
  always @(posedge clk_i)
  begin
    fwd_o <= 1'b0;
    if (rst_i)
    begin
      wr_ptr  <= 9'h0;
      rd_ptr  <= 9'h0;
      cnt     <= 10'h0;
      fwd_act <= 1'b0;
    end
    else
    begin
      if (rx_done && !buf_full && !fwd_act)
      begin
        buf_mem[wr_ptr] <= rx_byte;
        wr_ptr <= wr_ptr + 9'h1;
      end
      cnt <= cnt + ((rx_done && !buf_full && !fwd_act) ? 10'h1 : 10'h0)
                 - (rd_pop ? 10'h1 : 10'h0);
      if (!fwd_act && (buf_full || gap_hit))
      begin
        fwd_act <= 1'b1;
        fwd_o   <= 1'b1;
      end
      else if (fwd_act && rd_pop && cnt == 10'h1)
        fwd_act <= 1'b0;
      if (rd_pop)
        rd_ptr <= rd_ptr + 9'h1;
    end
  end

  // Modem lines and connection requests
  wire tcp_mode = (mode_c != `SPP_HM_UDP_SRV);
  assign accept_ok_o = (mode_c == `SPP_HM_TCP_SRV && dsr_c == `SPP_DSR_GATE)
                       ? dsr_i : 1'b1;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dtr_o        <= 1'b1;
      conn_open_o  <= 1'b0;
      conn_close_o <= 1'b0;
    end
    else
    begin
      case (dtr_c)
        `SPP_DTR_LOW:  dtr_o <= 1'b0;
        `SPP_DTR_CONN: dtr_o <= net_up_i;
        default:       dtr_o <= 1'b1;
      endcase
      conn_open_o <= (mode_c == `SPP_HM_TCP_CLI) && (dsr_c == `SPP_DSR_OPEN)
                     && dsr_i && !net_up_i;
      conn_close_o <= net_up_i && (inact_hit
                     || (tcp_mode && (net_req_i || probe_fail_i))
                     || ((mode_c == `SPP_HM_TCP_CLI)
                         && (dsr_c == `SPP_DSR_OPEN) && !dsr_i));
    end
  end

  // Register writes and status flags
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg     <= `SPP_CFG_RESET;
      ict_ms  <= 14'h0;
      inact_s <= 12'h0;
      tx_hold <= 8'h0;
      tx_pend <= 1'b0;
      rx_perr <= 1'b0;
      rx_ovr  <= 1'b0;
    end
    else
    begin
      if (wr_i && addr_i == `SPP_REG_CFG)
        cfg <= wdata_i;
      if (wr_i && addr_i == `SPP_REG_ICT && wdata_i <= `SPP_ICT_MAX)
        ict_ms <= wdata_i[13:0];
      if (wr_i && addr_i == `SPP_REG_INACT && wdata_i <= `SPP_INACT_MAX)
        inact_s <= wdata_i[11:0];
      if (wr_tx && !tx_pend)
      begin
        tx_hold <= wdata_i[7:0];
        tx_pend <= 1'b1;
      end
      else if (tx_go && tx_st == TX_IDLE)
        tx_pend <= 1'b0;
      // Set wins over a clear in the same cycle
      if (rx_pbad)
        rx_perr <= 1'b1;
      else if (wr_i && addr_i == `SPP_REG_STAT && wdata_i[0])
        rx_perr <= 1'b0;
      if (rx_done && (buf_full || fwd_act))
        rx_ovr <= 1'b1;
      else if (wr_i && addr_i == `SPP_REG_STAT && wdata_i[1])
        rx_ovr <= 1'b0;
    end
  end

  // Register reads, one cycle after the strobe
  always @(posedge clk_i)
  begin
    if (rst_i)
      rdata_o <= 32'h0;
    else if (rd_i)
    begin
      case (addr_i)
        `SPP_REG_CFG:    rdata_o <= cfg;
        `SPP_REG_ICT:    rdata_o <= {18'h0, ict_ms};
        `SPP_REG_INACT:  rdata_o <= {20'h0, inact_s};
        `SPP_REG_STAT:   rdata_o <= {24'h0, fwd_act, buf_full, net_up_i,
                                     dsr_i, tx_pend, tx_st != TX_IDLE,
                                     rx_ovr, rx_perr};
        `SPP_REG_RXDATA: rdata_o <= fwd_act ? {24'h0, buf_mem[rd_ptr]}
                                            : 32'h0;
        `SPP_REG_RXCNT:  rdata_o <= {22'h0, cnt};
        default:         rdata_o <= 32'h0;
      endcase
    end
  end

endmodule // spp_top

`default_nettype wire

// file: sim/spp_assertions.sv
// Port-level checker for the serial packetizer block
`timescale 1ns/1ps
`default_nettype none
`include "spp_consts.vh"
module spp_checker
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [3:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        txd_o,
  input wire logic        rts_o,
  input wire logic        dtr_o,
  input wire logic        dsr_i,
  input wire logic        net_up_i,
  input wire logic        probe_fail_i,
  input wire logic        conn_open_o,
  input wire logic        conn_close_o,
  input wire logic        accept_ok_o,
  input wire logic        fwd_o
);
  // 9600, 8 data, no parity, 1 stop, no flow, DTR high, DSR off, client
  localparam logic [31:0] CFG_DEF = 32'h00015564;
  logic [31:0] cfg;
  logic        quiet;
  logic [1:0]  dtr;
  logic [1:0]  dsr;
  logic [1:0]  hm;
  logic [1:0]  flow;
  // Shadow copy of the configuration word
  always @(posedge clk_i)
  begin
    if (rst_i)
      cfg <= CFG_DEF;
    else if (wr_i && addr_i == `SPP_REG_CFG)
      cfg <= wdata_i;
  end
  // Field views and a flag for no configuration write
  assign quiet = !(wr_i && addr_i == `SPP_REG_CFG);
  assign dtr = cfg[`SPP_CFG_DTR_LSB +: 2];
  assign dsr = cfg[`SPP_CFG_DSR_LSB +: 2];
  assign hm = cfg[`SPP_CFG_MODE_LSB +: 2];
  assign flow = cfg[`SPP_CFG_FLOW_LSB +: 2];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_cfg_readback: assert property (rd_i && addr_i == `SPP_REG_CFG
    |=> rdata_o == $past(cfg)) else $error("config read mismatch");
  a_gap_limit: assert property (rd_i && addr_i == `SPP_REG_ICT
    |=> rdata_o <= `SPP_ICT_MAX) else $error("gap timeout above limit");
  a_idle_limit: assert property (rd_i && addr_i == `SPP_REG_INACT
    |=> rdata_o <= `SPP_INACT_MAX) else $error("inactivity above limit");
  a_dtr_policy: assert property ((quiet && $stable(net_up_i))[*4]
    |-> dtr_o == (dtr == `SPP_DTR_LOW ? 1'b0 :
                  dtr == `SPP_DTR_CONN ? net_up_i : 1'b1))
    else $error("DTR level wrong");
  a_rts_noflow: assert property ((quiet && flow != `SPP_FLOW_HW)[*2]
    |-> rts_o) else $error("RTS low without flow control");
  a_accept_gate: assert property
    ((quiet && $stable(dsr_i) && hm != `SPP_HM_UDP_SRV)[*4]
    |-> accept_ok_o == ((dsr == `SPP_DSR_GATE && hm == `SPP_HM_TCP_SRV)
                        ? dsr_i : 1'b1)) else $error("accept gating wrong");
  a_dsr_open: assert property ((quiet && dsr == `SPP_DSR_OPEN
    && hm == `SPP_HM_TCP_CLI && dsr_i && !net_up_i)[*4] |-> conn_open_o)
    else $error("no open request on DSR high");
  a_dsr_close: assert property ((quiet && dsr == `SPP_DSR_OPEN
    && hm == `SPP_HM_TCP_CLI && !dsr_i && net_up_i)[*4] |-> conn_close_o)
    else $error("no close request on DSR low");
  a_probe_close: assert property ((quiet && net_up_i
    && probe_fail_i && hm != `SPP_HM_UDP_SRV)[*4] |-> conn_close_o)
    else $error("no close on failed probe");
  a_fwd_pulse: assert property (fwd_o |=> !fwd_o)
    else $error("forward pulse too long");
  c_open: cover property (conn_open_o);
  c_close: cover property (conn_close_o);
  c_tx_start: cover property ($fell(txd_o));
endmodule // spp_checker
bind spp_top spp_checker u_chk (.*);
`default_nettype wire

// file: sim/spp_serial_model.sv
// Attached serial device: frame decoder and frame sender
`timescale 1ns/1ps
`default_nettype none
`include "spp_consts.vh"
module spp_serial_model
(
  input  wire logic        clk_i,
  input  wire logic        txd_i,
  input  wire logic        rts_i,
  input  wire logic [15:0] bit_i,
  input  wire logic        seven_i,
  input  wire logic [1:0]  par_i,
  input  wire logic        stop2_i,
  output var  logic        rxd_o = 1'b1,
  output var  logic        got_o = 1'b0,
  output var  logic [7:0]  byte_o = 8'h00,
  output var  logic        ok_o = 1'b0
);
  logic [7:0] b;
  logic       ok;
  task automatic bt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Decode a frame from the block, mid-bit sampling
  always
  begin
    @(negedge txd_i);
    bt(bit_i / 2);
    ok = !txd_i;
    b = 8'h00;
    for (int i = 0; i < (seven_i ? 7 : 8); i++)
    begin
      bt(bit_i);
      b[i] = txd_i;
    end
    if (par_i != `SPP_PAR_NONE)
    begin
      bt(bit_i);
      ok = ok && ((^b ^ txd_i) == (par_i == `SPP_PAR_ODD));
    end
    for (int i = 0; i < (stop2_i ? 2 : 1); i++)
    begin
      bt(bit_i);
      ok = ok && txd_i;
    end
    byte_o <= b;
    ok_o <= ok;
    got_o <= 1'b1;
    bt(1);
    got_o <= 1'b0;
  end
  // Send one frame toward the block, parity spoiled on request
  task automatic send(input logic [7:0] d, input logic bad);
    for (int k = 0; k < 100000 && rts_i !== 1'b1; k++) bt(1);
    rxd_o <= 1'b0;
    bt(bit_i);
    for (int i = 0; i < (seven_i ? 7 : 8); i++)
    begin
      rxd_o <= d[i];
      bt(bit_i);
    end
    if (par_i != `SPP_PAR_NONE)
    begin
      rxd_o <= ^(d & {!seven_i, 7'h7F}) ^ (par_i == `SPP_PAR_ODD) ^ bad;
      bt(bit_i);
    end
    rxd_o <= 1'b1;
    bt(stop2_i ? bit_i * 2 : bit_i);
  endtask
endmodule // spp_serial_model
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the serial packetizer block
`timescale 1ns/1ps
`default_nettype none
`include "spp_consts.vh"
module tb_top;
  localparam int B8 = `SPP_CLK_HZ / 115200;
  localparam int B7 = `SPP_CLK_HZ / 57600;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [3:0]  addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h00000000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        cts_i = 1'b1;
  logic        dsr_i = 1'b0;
  logic        net_up_i = 1'b0;
  logic        net_req_i = 1'b0;
  logic        probe_fail_i = 1'b0;
  logic [31:0] rdata_o;
  logic        rxd_i, txd_o, rts_o, dtr_o, fwd_o;
  logic        conn_open_o, conn_close_o, accept_ok_o;
  logic [15:0] bit_c = 16'h0000;
  logic        seven = 1'b0;
  logic [1:0]  par = 2'h1;
  logic        stop2 = 1'b0;
  logic        got, fok, rd_pend = 1'b0;
  logic [7:0]  gbyte;
  logic [31:0] eq[$];
  logic [31:0] mq[$];
  logic [7:0]  tq[$];
  logic [31:0] seed = 32'h0001471C;
  int          mismatches = 0;
  int          checks = 0;
  always #4 clk_i = ~clk_i;
  spp_top u_dut (.*);
  spp_serial_model u_dev (.clk_i(clk_i), .txd_i(txd_o), .rts_i(rts_o),
    .bit_i(bit_c), .seven_i(seven), .par_i(par), .stop2_i(stop2),
    .rxd_o(rxd_i), .got_o(got), .byte_o(gbyte), .ok_o(fok));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Counts: checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Read with a note of the expected masked value
  task automatic rd(input logic [3:0] a, input logic [31:0] e, m);
    eq.push_back(e & m);
    mq.push_back(m);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic cfg(input logic [3:0] bd, input logic [1:0] db, pa, st,
                     input logic [1:0] fl, dt, ds, hm);
    wr(`SPP_REG_CFG, {14'h0000, hm, ds, dt, fl, st, pa, db, bd});
    bit_c <= (bd == 4'h8) ? B8[15:0] : B7[15:0];
    seven <= (db == `SPP_DB_SEVEN);
    par <= pa;
    stop2 <= (st == `SPP_STOP_TWO);
  endtask
  task automatic wait_tx(input int n);
    for (int k = 0; k < n && tq.size() != 0; k++) @(posedge clk_i);
    if (tq.size() != 0)
    begin
      mismatches++;
      end_of_test();
    end
    else
      idle(bit_c * 2);
  endtask
  // Compare read data and decoded frames with the oldest notes
  always @(posedge clk_i)
  begin
    if (rd_pend)
      chk(rdata_o & mq.pop_front(), eq.pop_front());
    rd_pend <= rd_i;
    if (got === 1'b1)
    begin
      chk({31'h0, fok}, 32'h1);
      chk({24'h0, gbyte}, {24'h0, tq.pop_front()});
    end
  end
  // Watchdog against hangs
  initial
  begin
    idle(98000);
    mismatches++;
    end_of_test();
  end
  // Main sequence
  initial
  begin
    logic [31:0] d;
    logic        hi;
    idle(20);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(`SPP_REG_CFG, 32'h00015564, 32'h00000FF0);
    chk(dtr_o, 1);
    chk(txd_o, 1);
    $display("Test reset finished");
    cfg(4'h8, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1);
    d = xs();
    tq.push_back(d[7:0]);
    wr(`SPP_REG_TXDATA, {24'h0, d[7:0]});
    wait_tx(B8 * 12);
    cfg(4'h7, `SPP_DB_SEVEN, `SPP_PAR_EVEN, `SPP_STOP_TWO, 2'h1, 2'h1,
        2'h1, 2'h1);
    d = xs();
    tq.push_back({1'b0, d[6:0]});
    wr(`SPP_REG_TXDATA, {24'h0, d[7:0]});
    wait_tx(B7 * 14);
    $display("Test transmit framing finished");
    cfg(4'h8, 2'h2, `SPP_PAR_ODD, 2'h1, `SPP_FLOW_HW, 2'h1, 2'h1, 2'h1);
    cts_i <= 1'b0;
    d = xs();
    tq.push_back(d[7:0]);
    wr(`SPP_REG_TXDATA, {24'h0, d[7:0]});
    hi = 1'b1;
    for (int k = 0; k < B8 * 2; k++)
    begin
      @(posedge clk_i);
      hi = hi & txd_o;
    end
    chk(hi, 1);
    chk(rts_o, 1);
    cts_i <= 1'b1;
    wait_tx(B8 * 12);
    $display("Test flow control finished");
    u_dev.send(xs(), 1'b0);
    rd(`SPP_REG_RXCNT, 32'h00000001, 32'hFFFFFFFF);
    u_dev.send(xs(), 1'b1);
    rd(`SPP_REG_STAT, 32'h00000001, 32'h00000081);
    rd(`SPP_REG_RXDATA, 32'h00000000, 32'hFFFFFFFF);
    $display("Test receive finished");
    for (int c = 1; c <= 3; c++)
      for (int u = 0; u < 2; u++)
      begin
        net_up_i <= u[0];
        cfg(4'h8, 2'h2, 2'h1, 2'h1, 2'h1, c[1:0], 2'h1, 2'h1);
        idle(6);
        chk(dtr_o, c == 2 ? 0 : (c == 3 ? u : 1));
      end
    $display("Test DTR policy finished");
    net_up_i <= 1'b0;
    cfg(4'h8, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1, `SPP_DSR_GATE, `SPP_HM_TCP_SRV);
    for (int v = 0; v < 2; v++)
    begin
      dsr_i <= v[0];
      idle(6);
      chk(accept_ok_o, v);
    end
    cfg(4'h8, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, `SPP_HM_TCP_SRV);
    dsr_i <= 1'b0;
    idle(6);
    chk(accept_ok_o, 1);
    cfg(4'h8, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1, `SPP_DSR_OPEN, `SPP_HM_TCP_CLI);
    dsr_i <= 1'b1;
    idle(6);
    chk(conn_open_o, 1);
    dsr_i <= 1'b0;
    net_up_i <= 1'b1;
    idle(6);
    chk(conn_close_o, 1);
    cfg(4'h8, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, `SPP_HM_TCP_CLI);
    idle(6);
    chk(conn_close_o, 0);
    probe_fail_i <= 1'b1;
    idle(6);
    chk(conn_close_o, 1);
    probe_fail_i <= 1'b0;
    net_req_i <= 1'b1;
    idle(6);
    chk(conn_close_o, 1);
    net_req_i <= 1'b0;
    cfg(4'h8, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, `SPP_HM_UDP_SRV);
    probe_fail_i <= 1'b1;
    idle(6);
    chk(conn_close_o, 0);
    probe_fail_i <= 1'b0;
    net_up_i <= 1'b0;
    $display("Test DSR policy finished");
    wr(`SPP_REG_ICT, 32'h00002710);
    wr(`SPP_REG_ICT, 32'h00002711);
    rd(`SPP_REG_ICT, 32'h00002710, 32'hFFFFFFFF);
    wr(`SPP_REG_INACT, 32'h00000E10);
    wr(`SPP_REG_INACT, 32'h00000E11);
    rd(`SPP_REG_INACT, 32'h00000E10, 32'hFFFFFFFF);
    rd(4'hF, 32'h00000000, 32'hFFFFFFFF);
    idle(4);
    chk(eq.size() + tq.size(), 0);
    $display("Test limits finished");
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
